/* core/scwb_bank.sv */
// Purpose: write-only bank of six configuration words
// Assumes: serial decoding outside; word arrives with one-cycle strobe
// Notes: reset loads recommended values so outputs are sane at once
`timescale 1ns/10ps
`include "scwb_defines.svh"
module scwb_bank
  import scwb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // incoming word from the serial receiver
  input wire logic word_valid,
  input wire scwb_word_t word_data,
  // oscillator and output settings
  output logic oscillator_choice,
  output logic [1:0] prescale_field,
  output logic [2:0] post_divide_field,
  output logic output_standard_choice,
  output logic fixed_one_bit,
  output logic [5:0] prescale_ratio,
  output logic [5:0] post_ratio,
  output logic post_code_bad,
  // loop settings
  output logic [18:0] loop_filter_setting,
  output logic [3:0] pump_current_field,
  output logic fixed_zero_bit,
  // calibration
  output logic [5:0] calibration_value,
  output logic calibration_override,
  output logic calibration_enable,
  // test
  output logic [3:0] factory_test_field,
  // bookkeeping
  output logic [5:0] word_loaded,
  output logic select_ignored
);
  scwb_sel_t sel;
  logic [5:0] wr_en;
  logic sel_bad;
  scwb_word_t word0_q;
  scwb_word_t word0_d;
  scwb_word_t word1_q;
  scwb_word_t word2_q;
  scwb_word_t word3_q;
  scwb_word_t word4_q;
  scwb_word_t word5_q;
  logic [5:0] loaded_q;
  logic ignored_q;
  scwb_ratio_t presc_ratio_q;
  scwb_ratio_t post_ratio_q;
  logic post_bad_q;
  scwb_dec_if dif ();

  assign sel = word_data[`SCWB_SEL_MSB:`SCWB_SEL_LSB];

  // one write enable per word; codes 6 and 7 reach no word
  always_comb
  begin
    wr_en = 6'h00;
    sel_bad = 1'b0;
    if (!word_valid)
    begin
      wr_en = 6'h00;
    end
    else if (sel == `SCWB_SEL_W0)
    begin
      wr_en = 6'h01;
    end
    else if (sel == `SCWB_SEL_W1)
    begin
      wr_en = 6'h02;
    end
    else if (sel == `SCWB_SEL_W2)
    begin
      wr_en = 6'h04;
    end
    else if (sel == `SCWB_SEL_W3)
    begin
      wr_en = 6'h08;
    end
    else if (sel == `SCWB_SEL_W4)
    begin
      wr_en = 6'h10;
    end
    else if (sel == `SCWB_SEL_W5)
    begin
      wr_en = 6'h20;
    end
    else
    begin
      sel_bad = 1'b1;
    end
  end

  // next value of word 0; the ratio decoder works on it so that the
  // registered ratios change on the same edge as the field outputs
  always_comb
  begin
    word0_d = word0_q;
    if (rst)
    begin
      word0_d = `SCWB_RST_W0;
    end
    else if (wr_en[0])
    begin
      word0_d = word_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    word0_q <= word0_d;
  end

  // select bits are stored with the payload but drive no output
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      word1_q <= `SCWB_RST_W1;
    end
    else if (wr_en[1])
    begin
      word1_q <= word_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      word2_q <= `SCWB_RST_W2;
    end
    else if (wr_en[2])
    begin
      word2_q <= word_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      word3_q <= `SCWB_RST_W3;
    end
    else if (wr_en[3])
    begin
      word3_q <= word_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      word4_q <= `SCWB_RST_W4;
    end
    else if (wr_en[4])
    begin
      word4_q <= word_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      word5_q <= `SCWB_RST_W5;
    end
    else if (wr_en[5])
    begin
      word5_q <= word_data;
    end
  end

  // ratios registered so data outputs come from flops; in reset they
  // take the decode of the reset word, so no extra constants are kept
  always_ff @(posedge ref_clk)
  begin
    presc_ratio_q <= dif.prescale_ratio;
    post_ratio_q <= dif.post_ratio;
    post_bad_q <= dif.post_code_bad;
  end

  // sticky record of which words the host has written since reset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      loaded_q <= 6'h00;
    end
    else
    begin
      loaded_q <= loaded_q | wr_en;
    end
  end

  // level flag: the last word offered carried select code 6 or 7
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ignored_q <= 1'b0;
    end
    else if (word_valid)
    begin
      ignored_q <= sel_bad;
    end
  end

  assign oscillator_choice = word0_q[`SCWB_OSC_BIT];
  assign prescale_field =
    word0_q[`SCWB_PRESC_MSB:`SCWB_PRESC_LSB];
  assign post_divide_field =
    word0_q[`SCWB_POST_MSB:`SCWB_POST_LSB];
  assign output_standard_choice = word0_q[`SCWB_STD_BIT];
  // exported so the startup logic can see a bad host value
  assign fixed_one_bit = word0_q[`SCWB_FIX1_BIT];
  assign loop_filter_setting = {
    word3_q[`SCWB_LF_HI_MSB:`SCWB_PAY_LSB],
    word2_q[`SCWB_PAY_MSB:`SCWB_PAY_LSB],
    word1_q[`SCWB_PAY_MSB:`SCWB_PAY_LSB]};
  assign pump_current_field =
    word3_q[`SCWB_PUMP_MSB:`SCWB_PUMP_LSB];
  assign fixed_zero_bit = word3_q[`SCWB_FIX0_BIT];
  assign calibration_value =
    word4_q[`SCWB_CAL_MSB:`SCWB_CAL_LSB];
  assign calibration_override = word4_q[`SCWB_CALOV_BIT];
  assign calibration_enable = word4_q[`SCWB_CALEN_BIT];
  assign factory_test_field =
    word5_q[`SCWB_TEST_MSB:`SCWB_TEST_LSB];
  assign word_loaded = loaded_q;
  assign select_ignored = ignored_q;

  assign dif.prescale_field = word0_d[`SCWB_PRESC_MSB:`SCWB_PRESC_LSB];
  assign dif.post_divide_field = word0_d[`SCWB_POST_MSB:`SCWB_POST_LSB];
  assign prescale_ratio = presc_ratio_q;
  assign post_ratio = post_ratio_q;
  assign post_code_bad = post_bad_q;

  scwb_ratio_dec u_dec (
    .dec(dif.dec)
  );
endmodule // scwb_bank

/* shared/scwb_defines.svh */
// Purpose: constants of the synthesizer configuration word bank
// Assumes: 11-bit words, select code in bits 0 to 2
// Notes: Operation list follows
// Operation
// - bits 0-2 select target word; code N loads word N, N 0..5
// - word 0 bit 3 chooses first (0) or second (1) oscillator
// - word 0 bits 5:4 prescale: 00=5, 01=3, 10=4, 11=2
// - word 0 bits 8:6 post divide: 000..101 give 1,2,4,8,16,32
// - word 0 bit 9: 0 low-voltage differential, 1 emitter-coupled
// - 19-bit loop filter spread over words 1, 2, 3 bits 3 up
// - word 3 bits 9:6 pump current, recommended all ones
// - word 4: calibration value 8:3, override 9, enable 10
`ifndef SCWB_DEFINES_SVH
`define SCWB_DEFINES_SVH
`define SCWB_WORD_W 11
`define SCWB_SEL_LSB 0
`define SCWB_SEL_MSB 2
`define SCWB_NUM_WORDS 6
`define SCWB_SEL_W0 3'h0
`define SCWB_SEL_W1 3'h1
`define SCWB_SEL_W2 3'h2
`define SCWB_SEL_W3 3'h3
`define SCWB_SEL_W4 3'h4
`define SCWB_SEL_W5 3'h5
`define SCWB_OSC_BIT 3
`define SCWB_PRESC_LSB 4
`define SCWB_PRESC_MSB 5
`define SCWB_POST_LSB 6
`define SCWB_POST_MSB 8
`define SCWB_STD_BIT 9
`define SCWB_FIX1_BIT 10
`define SCWB_PAY_LSB 3
`define SCWB_PAY_MSB 10
`define SCWB_LF_HI_MSB 5
`define SCWB_PUMP_LSB 6
`define SCWB_PUMP_MSB 9
`define SCWB_FIX0_BIT 10
`define SCWB_CAL_LSB 3
`define SCWB_CAL_MSB 8
`define SCWB_CALOV_BIT 9
`define SCWB_CALEN_BIT 10
`define SCWB_TEST_LSB 3
`define SCWB_TEST_MSB 6
`define SCWB_RST_W0 11'h400
`define SCWB_RST_W1 11'h2f9
`define SCWB_RST_W2 11'h01a
`define SCWB_RST_W3 11'h3c3
`define SCWB_RST_W4 11'h404
`define SCWB_RST_W5 11'h005
`endif

/* shared/scwb_pkg.sv */
// Purpose: types of the configuration word bank
// Assumes: constants live in scwb_defines.svh
// Notes: none
`include "scwb_defines.svh"
package scwb_pkg;
  typedef logic [`SCWB_WORD_W-1:0] scwb_word_t;
  typedef logic [`SCWB_SEL_MSB:0] scwb_sel_t;
  typedef logic [5:0] scwb_ratio_t;
endpackage

/* shared/scwb_dec_if.sv */
// Purpose: carries decoded divide ratios between bank and decoder
// Assumes: single clock
// Notes: none
`timescale 1ns/10ps
interface scwb_dec_if;
  import scwb_pkg::*;
  logic [1:0] prescale_field;
  logic [2:0] post_divide_field;
  scwb_ratio_t prescale_ratio;
  scwb_ratio_t post_ratio;
  logic post_code_bad;
  modport bank (output prescale_field, output post_divide_field,
    input prescale_ratio, input post_ratio, input post_code_bad);
  modport dec (input prescale_field, input post_divide_field,
    output prescale_ratio, output post_ratio, output post_code_bad);
endinterface

/* core/scwb_ratio_dec.sv */
// Purpose: maps prescale and post-divide codes to divide ratios
// Assumes: codes come from the next value of bank word 0, ahead of its register
// Notes: undefined post codes give ratio zero and raise a flag
`timescale 1ns/10ps
module scwb_ratio_dec
  import scwb_pkg::*;
(
  // decoded fields
  scwb_dec_if.dec dec
);
  always_comb
  begin
    case (dec.prescale_field)
      2'h0: dec.prescale_ratio = 6'h05;
      2'h1: dec.prescale_ratio = 6'h03;
      2'h2: dec.prescale_ratio = 6'h04;
      default: dec.prescale_ratio = 6'h02;
    endcase
  end

  always_comb
  begin
    dec.post_code_bad = 1'b0;
    case (dec.post_divide_field)
      3'h0: dec.post_ratio = 6'h01;
      3'h1: dec.post_ratio = 6'h02;
      3'h2: dec.post_ratio = 6'h04;
      3'h3: dec.post_ratio = 6'h08;
      3'h4: dec.post_ratio = 6'h10;
      3'h5: dec.post_ratio = 6'h20;
      default:
      begin
        // no ratio exists; flag it rather than guess one
        dec.post_ratio = 6'h00;
        dec.post_code_bad = 1'b1;
      end
    endcase
  end
endmodule // scwb_ratio_dec

/* test/scwb_bank_assertions.sv */
// Purpose: bank checks
// Assumes: word_data qualified by word_valid
// Notes: none
`timescale 1ns/10ps
module scwb_bank_chk
(
  // watched ports
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic word_valid,
  input wire logic [10:0] word_data,
  input wire logic oscillator_choice,
  input wire logic [1:0] prescale_field,
  input wire logic [2:0] post_divide_field,
  input wire logic [5:0] post_ratio,
  input wire logic post_code_bad,
  input wire logic [18:0] loop_filter_setting,
  input wire logic [3:0] pump_current_field,
  input wire logic calibration_enable,
  input wire logic select_ignored
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire [2:0] s = word_data[2:0];
  wire w = word_valid;
  a_other_word: assert property (w && s == 3'h2 |=>
    $stable(oscillator_choice)) else $error("osc moved");
  a_osc_load: assert property (w && s == 3'h0 |=>
    oscillator_choice == $past(word_data[3])) else $error("osc");
  a_presc_load: assert property (w && s == 3'h0 |=>
    prescale_field == $past(word_data[5:4])) else $error("presc");
  a_post_map: assert property (
    post_code_bad == (post_divide_field > 3'h5)
    && (post_code_bad || post_ratio == 6'h01 << post_divide_field))
    else $error("post");
  a_filter_low: assert property (w && s == 3'h1 |=>
    loop_filter_setting[7:0] == $past(word_data[10:3])) else $error("lf");
  a_pump_load: assert property (w && s == 3'h3 |=>
    pump_current_field == $past(word_data[9:6])) else $error("pump");
  a_cal_enable: assert property (w && s == 3'h4 |=>
    calibration_enable == $past(word_data[10])) else $error("cal");
  a_bad_select: assert property (w && s[2:1] == 2'h3 |=>
    select_ignored && $stable(loop_filter_setting)) else $error("ign");
  c_word0: cover property (w && s == 3'h0);
  c_word3: cover property (w && s == 3'h3);
  c_ignored: cover property (select_ignored);
endmodule // scwb_bank_chk
bind scwb_bank scwb_bank_chk u_scwb_bank_chk (.*);

/* test/scwb_host.sv */
// Purpose: host model sending configuration words
// Assumes: one-cycle valid, idle cycle between words
// Notes: fixed bits forced, so this host never breaks them
`timescale 1ns/10ps
module scwb_host
(
  // clock
  input wire logic ref_clk,
  // word toward the bank
  output logic word_valid,
  output logic [10:0] word_data
);
  initial
  begin
    word_valid = 1'b0;
    word_data = 11'h000;
  end
  task automatic send(input logic [2:0] s, input logic [7:0] p);
    if (s == 3'h0) p[7] = 1'b1;
    if (s == 3'h0 && p[5:3] > 3'h5) p[5:3] = 3'h5;
    if (s == 3'h3) p[7] = 1'b0;
    if (s == 3'h5) p = 8'h00;
    @(posedge ref_clk);
    #1;
    word_valid = 1'b1;
    word_data = {p, s};
    @(posedge ref_clk);
    #1;
    word_valid = 1'b0;
    word_data = ~word_data; // stale data must not look valid
  endtask
endmodule // scwb_host

/* test/tb_top.sv */
// Purpose: directed bench for the word bank
// Assumes: host model drives the words
// Notes: expectations built from the field layout
`timescale 1ns/10ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic word_valid, oscillator_choice, output_standard_choice;
  logic fixed_one_bit, fixed_zero_bit, post_code_bad, select_ignored;
  logic calibration_override, calibration_enable;
  logic [10:0] word_data;
  logic [1:0] prescale_field;
  logic [2:0] post_divide_field;
  logic [5:0] prescale_ratio, post_ratio, calibration_value, word_loaded;
  logic [3:0] pump_current_field, factory_test_field;
  logic [18:0] loop_filter_setting;
  logic [5:0] pre [4] = '{6'h05, 6'h03, 6'h04, 6'h02};
  int mismatches = 0;
  int total_checks = 0;
  scwb_bank u_scwb_bank (.*);
  scwb_host u_scwb_host (.*);
  task automatic chk(input string n, input logic [18:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #100000;
    mismatches++;
    finish_test();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk("lf", 19'h0035f, loop_filter_setting);
    chk("fix", 6'h2f,
      {fixed_one_bit, fixed_zero_bit, pump_current_field});
    for (int k = 0; k < 6; k++)
    begin
      u_scwb_host.send(3'h0, {1'b1, k[1], k[2:0], k[1:0], k[0]});
      chk("osc", k[0], oscillator_choice);
      chk("presc", pre[k[1:0]], prescale_ratio);
      chk("post", 6'h01 << k, post_ratio);
      chk("std", k[1], output_standard_choice);
      chk("fields", {k[2:0], k[1:0]},
        {post_divide_field, prescale_field});
      chk("bad", 1'b0, post_code_bad);
    end
    u_scwb_host.send(3'h1, 8'ha5);
    u_scwb_host.send(3'h2, 8'h3c);
    u_scwb_host.send(3'h3, 8'h4d);
    chk("lf", 19'h53ca5, loop_filter_setting);
    chk("pump", 4'h9, pump_current_field);
    u_scwb_host.send(3'h4, 8'h6a);
    chk("cal", 8'h6a, {calibration_enable, calibration_override,
      calibration_value});
    u_scwb_host.send(3'h7, 8'h00);
    u_scwb_host.send(3'h6, 8'hff);
    chk("ign", 2'h3, {select_ignored, oscillator_choice});
    u_scwb_host.send(3'h5, 8'hff);
    chk("tail", 11'h03f, {select_ignored, factory_test_field,
      word_loaded});
    u_scwb_host.send(3'h6, 8'h00);
    @(posedge ref_clk);
    #1 rst = 1'b1;
    @(posedge ref_clk);
    #1 rst = 1'b0;
    chk("lf", 19'h0035f, loop_filter_setting);
    chk("rst", 14'h0005, {word_loaded, select_ignored, oscillator_choice,
      prescale_ratio});
    finish_test();
  end
endmodule // tb_top
